/* vmtmc_defs.svh */
// Purpose: constants for the virtualization transition machine-check unit
// Assumes: one clock, synchronous active-high reset
// Notes:   register offsets are word byte addresses on the plain register port
`ifndef VMTMC_DEFS_SVH
`define VMTMC_DEFS_SVH

`define VMTMC_ADDR_W        4
`define VMTMC_OFF_CTRL      4'h0
`define VMTMC_OFF_STATUS    4'h4
`define VMTMC_OFF_MASK      4'h8
`define VMTMC_OFF_STATE     4'hC
// control fields
`define VMTMC_CTRL_MCE      0
`define VMTMC_CTRL_XBM12    1
`define VMTMC_CTRL_ENTRY_P  3:2
`define VMTMC_CTRL_EXIT_P   5:4
`define VMTMC_CTRL_RST      6'h00
// status bits
`define VMTMC_ST_MC_EXC     0
`define VMTMC_ST_SHUTDOWN   1
`define VMTMC_ST_ABORT      2
`define VMTMC_ST_EXIT       3
`define VMTMC_ST_ENTRY_FAIL 4
`define VMTMC_ST_W          5
`define VMTMC_MASK_RST      5'h00
// machine-check vector and gate
`define VMTMC_MC_VECTOR     8'h12
// exit reason and abort indicator codes
`define VMTMC_REASON_MC_ENTRY 8'h29
`define VMTMC_ABORT_MC      3'h5
`define VMTMC_ABORT_GMSR    3'h1
`define VMTMC_ABORT_PDPTE   3'h2
`define VMTMC_ABORT_CORRUPT 3'h3
`define VMTMC_ABORT_HMSR    3'h4

`endif

/* vmtmc_pkg.sv */
// Purpose: types for the virtualization transition machine-check unit
// Assumes: constants come from vmtmc_defs.svh
// Notes:   one-hot state codes written out
package vmtmc_pkg;

  typedef enum logic [5:0] {
    VMTMC_HOST     = 6'h01,
    VMTMC_GUEST    = 6'h02,
    VMTMC_ENTRY    = 6'h04,
    VMTMC_EXIT     = 6'h08,
    VMTMC_ROOTINS  = 6'h10,
    VMTMC_SHUTDOWN = 6'h20
  } vmtmc_state_t;

  // entry phase reported by the core
  typedef enum logic [1:0] {
    VMTMC_PH_CHECK  = 2'h0,
    VMTMC_PH_PART   = 2'h1,
    VMTMC_PH_LOADED = 2'h2
  } vmtmc_phase_t;

  // delivery outcome
  typedef enum logic [2:0] {
    VMTMC_DLV_NONE     = 3'h0,
    VMTMC_DLV_HOST_TBL = 3'h1,
    VMTMC_DLV_GST_TBL  = 3'h2,
    VMTMC_DLV_GST_EXIT = 3'h3,
    VMTMC_DLV_HOSTLOAD = 3'h4,
    VMTMC_DLV_ABORT    = 3'h5
  } vmtmc_dlv_t;

  typedef struct packed {
    logic enter_virt;   // enter_virtualization_instr / leave_virtualization_instr
    logic leave_virt;
    logic entry_start;
    logic entry_done;
    logic exit_start;
    logic exit_done;
    logic root_ins_done;
  } vmtmc_req_t;

  typedef struct packed {
    logic gmsr_fail;
    logic pdpte_fail;
    logic corrupt;
    logic hmsr_fail;
    logic host_chk_fail;
  } vmtmc_fail_t;

  typedef struct packed {
    vmtmc_dlv_t  kind;
    logic [7:0]  vector;
    logic [7:0]  reason;
    logic [2:0]  abort_code;
  } vmtmc_out_t;

endpackage

/* vmtmc_top.sv */
// Purpose: machine-check and failure handling across guest entry/exit
// Assumes: core reports transitions as one-cycle pulses; inputs synchronous
// Notes:   delivery choice per transition is steered by control policy fields
`timescale 1ns/10ps
`default_nettype none
`include "vmtmc_defs.svh"

module vmtmc_top
  import vmtmc_pkg::*;
(
  // clock and reset
  input  wire logic                     CLK,
  input  wire logic                     RST,
  // register port
  input  wire logic [`VMTMC_ADDR_W-1:0] ADDR,
  input  wire logic [31:0]              WDATA,
  input  wire logic                     WR,
  input  wire logic                     RD,
  output var  logic [31:0]              RDATA,
  // core transitions
  input  wire vmtmc_req_t               REQ,
  input  wire vmtmc_phase_t             ENTRY_PHASE,
  input  wire vmtmc_fail_t              FAIL,
  input  wire logic                     MC_EVENT,
  input  wire logic                     EXIT_DECIDED,
  // outcome
  output var  vmtmc_out_t               OUTCOME,
  output var  logic                     OUTCOME_VALID,
  output var  logic                     HOST_LOAD,
  output var  logic                     HALTED,
  output var  logic                     GUEST_MODE,
  output var  logic                     IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [5:0]              ctrl_r;
  logic [`VMTMC_ST_W-1:0]  status_r;
  logic [`VMTMC_ST_W-1:0]  status_nxt;
  logic [`VMTMC_ST_W-1:0]  mask_r;
  vmtmc_state_t            state_r;
  vmtmc_state_t            state_nxt;
  vmtmc_out_t              out_nxt;
  logic                    ovalid_nxt;
  logic                    hload_nxt;
  logic [`VMTMC_ST_W-1:0]  ev;

  wire mce       = ctrl_r[`VMTMC_CTRL_MCE];
  wire xbm12     = ctrl_r[`VMTMC_CTRL_XBM12];
  wire [1:0] ent_pol = ctrl_r[`VMTMC_CTRL_ENTRY_P];
  wire [1:0] ext_pol = ctrl_r[`VMTMC_CTRL_EXIT_P];

  wire wr_ctrl   = WR && (ADDR == `VMTMC_OFF_CTRL);
  wire wr_mask   = WR && (ADDR == `VMTMC_OFF_MASK);
  wire rd_status = RD && (ADDR == `VMTMC_OFF_STATUS);
  wire exit_fail = FAIL.gmsr_fail | FAIL.pdpte_fail | FAIL.corrupt | FAIL.hmsr_fail;

  // entry option chosen: a forbidden once guest loading began, b needs full load
  wire [1:0] ent_opt =
    (ent_pol == 2'h0 && ENTRY_PHASE == VMTMC_PH_CHECK)  ? 2'h0 :
    (ent_pol == 2'h1 && ENTRY_PHASE == VMTMC_PH_LOADED) ? 2'h1 :
    2'h2;

  wire [`VMTMC_ADDR_W-1:0] a = ADDR;
  wire [31:0] rd_mux =
    (a == `VMTMC_OFF_CTRL)   ? {26'h0, ctrl_r} :
    (a == `VMTMC_OFF_STATUS) ? {27'h0, status_r} :
    (a == `VMTMC_OFF_MASK)   ? {27'h0, mask_r} :
    (a == `VMTMC_OFF_STATE)  ? {26'h0, state_r} : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // transition decisions
  always_comb begin
    state_nxt          = state_r;
    out_nxt            = '0;
    out_nxt.vector     = `VMTMC_MC_VECTOR;
    ovalid_nxt         = 1'b0;
    hload_nxt          = 1'b0;
    ev                 = '0;
    unique case (state_r)
      VMTMC_HOST: begin
        if (REQ.entry_start) begin
          state_nxt = VMTMC_ENTRY;
        end else if (REQ.enter_virt || REQ.leave_virt) begin
          state_nxt = VMTMC_ROOTINS;
        end
      end
      VMTMC_ROOTINS: begin
        if (MC_EVENT) begin
          ovalid_nxt = 1'b1;
          if (mce) begin
            out_nxt.kind = VMTMC_DLV_HOST_TBL;
            ev[`VMTMC_ST_MC_EXC] = 1'b1;
            state_nxt = VMTMC_HOST;
          end else begin
            state_nxt = VMTMC_SHUTDOWN;
          end
        end else if (REQ.root_ins_done) begin
          state_nxt = VMTMC_HOST;
        end
      end
      VMTMC_ENTRY: begin
        if (MC_EVENT) begin
          ovalid_nxt = 1'b1;
          unique case (ent_opt)
            2'h0: begin
              out_nxt.kind = mce ? VMTMC_DLV_HOST_TBL : VMTMC_DLV_NONE;
              state_nxt    = mce ? VMTMC_HOST : VMTMC_SHUTDOWN;
            end
            2'h1: begin
              out_nxt.kind = xbm12 ? VMTMC_DLV_GST_EXIT : VMTMC_DLV_GST_TBL;
              state_nxt    = mce ? (xbm12 ? VMTMC_HOST : VMTMC_GUEST) : VMTMC_SHUTDOWN;
              if (!mce) out_nxt.kind = VMTMC_DLV_NONE;
            end
            default: begin
              out_nxt.kind   = VMTMC_DLV_HOSTLOAD;
              out_nxt.reason = `VMTMC_REASON_MC_ENTRY;
              hload_nxt      = 1'b1;
              ev[`VMTMC_ST_ENTRY_FAIL] = 1'b1;
              state_nxt      = VMTMC_HOST;
            end
          endcase
          ev[`VMTMC_ST_MC_EXC] = mce && (out_nxt.kind != VMTMC_DLV_HOSTLOAD);
        end else if (FAIL.host_chk_fail) begin
          state_nxt = VMTMC_HOST;
        end else if (REQ.entry_done) begin
          state_nxt = VMTMC_GUEST;
        end
      end
      VMTMC_GUEST: begin
        if (MC_EVENT && !EXIT_DECIDED) begin
          ovalid_nxt = 1'b1;
          if (!mce) begin
            state_nxt = VMTMC_SHUTDOWN;
          end else if (xbm12) begin
            out_nxt.kind = VMTMC_DLV_GST_EXIT;
            state_nxt    = VMTMC_EXIT;
            ev[`VMTMC_ST_MC_EXC] = 1'b1;
          end else begin
            out_nxt.kind = VMTMC_DLV_GST_TBL;
            ev[`VMTMC_ST_MC_EXC] = 1'b1;
          end
        end else if (REQ.exit_start) begin
          state_nxt = VMTMC_EXIT;
        end
      end
      VMTMC_EXIT: begin
        if (MC_EVENT) begin
          ovalid_nxt = 1'b1;
          unique case (ext_pol)
            2'h0: begin
              out_nxt.kind = !mce ? VMTMC_DLV_NONE :
                             xbm12 ? VMTMC_DLV_GST_EXIT : VMTMC_DLV_GST_TBL;
              state_nxt    = !mce ? VMTMC_SHUTDOWN : xbm12 ? VMTMC_EXIT : VMTMC_GUEST;
              ev[`VMTMC_ST_MC_EXC] = mce;
            end
            2'h1: begin
              out_nxt.kind = mce ? VMTMC_DLV_HOST_TBL : VMTMC_DLV_NONE;
              state_nxt    = mce ? VMTMC_HOST : VMTMC_SHUTDOWN;
              hload_nxt    = mce;
              ev[`VMTMC_ST_MC_EXC] = mce;
            end
            default: begin
              out_nxt.kind       = VMTMC_DLV_ABORT;
              out_nxt.abort_code = `VMTMC_ABORT_MC;
              ev[`VMTMC_ST_ABORT] = 1'b1;
              state_nxt          = VMTMC_SHUTDOWN;
            end
          endcase
        end else if (exit_fail) begin
          ovalid_nxt       = 1'b1;
          out_nxt.kind     = VMTMC_DLV_ABORT;
          out_nxt.abort_code = FAIL.gmsr_fail  ? `VMTMC_ABORT_GMSR :
                               FAIL.pdpte_fail ? `VMTMC_ABORT_PDPTE :
                               FAIL.corrupt    ? `VMTMC_ABORT_CORRUPT :
                                                 `VMTMC_ABORT_HMSR;
          ev[`VMTMC_ST_ABORT] = 1'b1;
          state_nxt        = VMTMC_SHUTDOWN;
        end else if (REQ.exit_done) begin
          hload_nxt = 1'b1;
          ev[`VMTMC_ST_EXIT] = 1'b1;
          state_nxt = VMTMC_HOST;
        end
      end
      VMTMC_SHUTDOWN: begin
        state_nxt = VMTMC_SHUTDOWN;
      end
      default: begin
        state_nxt = VMTMC_SHUTDOWN;
      end
    endcase
    if (state_nxt == VMTMC_SHUTDOWN && state_r != VMTMC_SHUTDOWN) begin
      ev[`VMTMC_ST_SHUTDOWN] = 1'b1;
    end
  end

  // set wins over read-clear
  assign status_nxt = (rd_status ? '0 : status_r) | ev;

  ////////////////////////////////////////////////////////////////////////////
  // state and registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_r       <= VMTMC_HOST;
      ctrl_r        <= `VMTMC_CTRL_RST;
      mask_r        <= `VMTMC_MASK_RST;
      status_r      <= '0;
      RDATA         <= 32'h0;
      OUTCOME       <= '0;
      OUTCOME_VALID <= 1'b0;
      HOST_LOAD     <= 1'b0;
      HALTED        <= 1'b0;
      GUEST_MODE    <= 1'b0;
      IRQ           <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      if (wr_ctrl) ctrl_r <= WDATA[5:0];
      if (wr_mask) mask_r <= WDATA[`VMTMC_ST_W-1:0];
      status_r      <= status_nxt;
      RDATA         <= RD ? rd_mux : 32'h0;
      OUTCOME       <= out_nxt;
      OUTCOME_VALID <= ovalid_nxt;
      HOST_LOAD     <= hload_nxt;
      HALTED        <= (state_nxt == VMTMC_SHUTDOWN);
      GUEST_MODE    <= (state_nxt == VMTMC_GUEST);
      IRQ           <= |(status_nxt & mask_r);
    end
  end

endmodule // vmtmc_top

`default_nettype wire

/* vmtmc_top_asserts.sv */
// Purpose: port-level checks for vmtmc_top
// Assumes: bound from the testbench top file
// Notes:   halts are sticky, so several checks key on HALTED
`timescale 1ns/10ps
`default_nettype none
`include "vmtmc_defs.svh"
module vmtmc_top_asserts
  import vmtmc_pkg::*;
(
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST,
  // register port
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  // transitions and outcome
  input wire vmtmc_req_t  REQ,
  input wire logic        MC_EVENT,
  input wire vmtmc_fail_t FAIL,
  input wire vmtmc_out_t  OUTCOME,
  input wire logic        OUTCOME_VALID,
  input wire logic        HOST_LOAD,
  input wire logic        HALTED
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  wire is_abort = OUTCOME_VALID && OUTCOME.kind == VMTMC_DLV_ABORT;
  wire is_shut  = OUTCOME_VALID && OUTCOME.kind == VMTMC_DLV_NONE;
  wire is_gate  = OUTCOME_VALID && OUTCOME.kind == VMTMC_DLV_GST_TBL;
  wire is_hload = OUTCOME_VALID && OUTCOME.kind == VMTMC_DLV_HOSTLOAD;
  ////////////////////////////////////////////////////////////////////////////
  AST_HALT_STICKY: assert property (HALTED |=> HALTED)
    else $error("halt left without reset");
  AST_HALT_QUIET: assert property (HALTED && $past(HALTED) |-> !OUTCOME_VALID && !HOST_LOAD)
    else $error("activity while halted");
  AST_SHUT_HALT: assert property (is_shut |-> ##[0:1] HALTED)
    else $error("shutdown without halt");
  AST_ABORT_HALT: assert property (is_abort |-> ##[0:1] HALTED)
    else $error("abort without halt");
  AST_GATE_VEC: assert property (is_gate |-> OUTCOME.vector == `VMTMC_MC_VECTOR)
    else $error("guest gate vector wrong");
  AST_ENTRY_REASON: assert property (is_hload |-> OUTCOME.reason == `VMTMC_REASON_MC_ENTRY)
    else $error("entry failure reason wrong");
  AST_LOAD_CAUSE: assert property ($rose(HOST_LOAD) |-> $past(REQ.exit_done || MC_EVENT))
    else $error("host load without cause");
  AST_OUT_CAUSE: assert property ($rose(OUTCOME_VALID) |->
    $past(MC_EVENT || REQ.exit_done || FAIL.gmsr_fail || FAIL.pdpte_fail ||
          FAIL.corrupt || FAIL.hmsr_fail))
    else $error("outcome without cause");
  AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data outside read slot");
  cover property (is_abort);
  cover property (is_hload);
  cover property (OUTCOME_VALID && OUTCOME.kind == VMTMC_DLV_GST_EXIT);
endmodule // vmtmc_top_asserts
`default_nettype wire

/* vmtmc_hv_model.sv */
// Purpose: hypervisor and error-source stand-in driving core hooks
// Assumes: one request pulse per call, one idle cycle after it
// Notes:   the idle cycle keeps pulses from merging
`timescale 1ns/10ps
`default_nettype none
module vmtmc_hv_model
  import vmtmc_pkg::*;
(
  // clock and halt view
  input wire logic   clk,
  input wire logic   halted,
  // toward the core hooks
  output var vmtmc_req_t req,
  output var logic   mc_event
);
  initial begin
    req = '0;
    mc_event = 1'b0;
  end
  task automatic send(input vmtmc_req_t r, input logic mc);
    @(posedge clk);
    // suspect state: nothing resumes once halted, only reset restarts
    if (!halted) begin
      req <= r;
      mc_event <= mc;
    end
    @(posedge clk);
    req <= '0;
    mc_event <= 1'b0;
  endtask
endmodule // vmtmc_hv_model
`default_nettype wire

/* vmtmc_top_tb_top.sv */
// Purpose: self-checking bench for vmtmc_top
// Assumes: case word hex digits = path,phase,ctrl(2),fail(2),kind,code,halt
// Notes:   every case starts from reset since halts are sticky
`timescale 1ns/10ps
`default_nettype none
`include "vmtmc_defs.svh"
module vmtmc_top_tb_top
  import vmtmc_pkg::*;
;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic [3:0]   addr = 4'h0;
  logic [31:0]  wdata = 32'h0;
  logic         wr = 1'b0;
  logic         rd = 1'b0;
  logic [31:0]  rdata;
  vmtmc_req_t   req;
  vmtmc_phase_t phase = VMTMC_PH_CHECK;
  vmtmc_fail_t  fail = '0;
  logic         mc;
  logic         xdec = 1'b0;
  vmtmc_out_t   outc;
  logic         ovalid, hload, halted, gmode, irq;
  logic [35:0]  c;
  int           fails = 0;
  int           comparisons = 0;
  logic [35:0]  cases [24] = '{36'h000100100, 36'h000000001, 36'h500100100,
    36'h100100100, 36'h100000001, 36'h110100400, 36'h120500200, 36'h120700300,
    36'h100500400, 36'h120900400, 36'h120400001, 36'h220100200, 36'h220300300,
    36'h221100100, 36'h221000001, 36'h222100551, 36'h220110511, 36'h220108521,
    36'h220104531, 36'h220102541, 36'h420100200, 36'h420300300, 36'h420000001,
    36'h220000001};
  always #5 clk = ~clk;
  vmtmc_top dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .REQ(req), .ENTRY_PHASE(phase), .FAIL(fail),
    .MC_EVENT(mc), .EXIT_DECIDED(xdec), .OUTCOME(outc), .OUTCOME_VALID(ovalid),
    .HOST_LOAD(hload), .HALTED(halted), .GUEST_MODE(gmode), .IRQ(irq));
  vmtmc_hv_model hv (.clk(clk), .halted(halted), .req(req), .mc_event(mc));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    fail <= '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic wait_hi(input bit load);
    int n = 0;
    #1;
    while ((load ? hload : ovalid) !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({31'h0, load ? hload : ovalid}, 32'h1);
  endtask
  // 0 enter, 5 leave, 1 entry, 2 into exit, 4 into guest
  task automatic run_path(input logic [3:0] p);
    case (p)
      4'h0: hv.send(vmtmc_req_t'(7'h40), 1'b0);
      4'h5: hv.send(vmtmc_req_t'(7'h20), 1'b0);
      4'h1: hv.send(vmtmc_req_t'(7'h10), 1'b0);
      default: begin
        hv.send(vmtmc_req_t'(7'h10), 1'b0);
        hv.send(vmtmc_req_t'(7'h08), 1'b0);
        if (p == 4'h2) hv.send(vmtmc_req_t'(7'h04), 1'b0);
      end
    endcase
  endtask
  task automatic end_of_test();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    fails++;
    end_of_test();
  end
  initial begin
    do_reset();
    rd_reg(`VMTMC_OFF_CTRL, 32'h0);
    rd_reg(`VMTMC_OFF_MASK, 32'h0);
    wr_reg(`VMTMC_OFF_CTRL, 32'h3F);
    rd_reg(`VMTMC_OFF_CTRL, 32'h3F);
    rd_reg(4'h2, 32'h0);
    $display("register test done");
    foreach (cases[i]) begin
      c = cases[i];
      do_reset();
      phase <= vmtmc_phase_t'(c[29:28]);
      wr_reg(`VMTMC_OFF_CTRL, {24'h0, c[27:20]});
      run_path(c[35:32]);
      // a failure is a level taken at once in exit, all others a lone event
      if (c[16:12] != 5'h0) begin
        fail <= vmtmc_fail_t'(c[16:12]);
      end else begin
        hv.send(vmtmc_req_t'(7'h00), 1'b1);
      end
      wait_hi(1'b0);
      chk({29'h0, outc.kind}, {29'h0, c[10:8]});
      if (c[10:8] == 3'h5) chk({29'h0, outc.abort_code}, {29'h0, c[6:4]});
      if (c[10:8] == 3'h4) chk({24'h0, outc.reason}, {24'h0, `VMTMC_REASON_MC_ENTRY});
      @(posedge clk);
      #1 chk({31'h0, halted}, {31'h0, c[0]});
      $display("case %0d done", i);
    end
    do_reset();
    wr_reg(`VMTMC_OFF_CTRL, 32'h1);
    run_path(4'h4);
    xdec <= 1'b1;
    hv.send(vmtmc_req_t'(7'h00), 1'b1);
    #1 chk({31'h0, ovalid}, 32'h0);
    chk({31'h0, gmode}, 32'h1);
    @(posedge clk);
    xdec <= 1'b0;
    $display("decided exit test done");
    do_reset();
    wr_reg(`VMTMC_OFF_MASK, 32'h8);
    run_path(4'h2);
    hv.send(vmtmc_req_t'(7'h02), 1'b0);
    wait_hi(1'b1);
    @(posedge clk);
    #1 chk({31'h0, irq}, 32'h1);
    rd_reg(`VMTMC_OFF_STATUS, 32'h8);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0);
    rd_reg(`VMTMC_OFF_STATUS, 32'h0);
    $display("exit and interrupt test done");
    end_of_test();
  end
endmodule // vmtmc_top_tb_top
bind vmtmc_top vmtmc_top_asserts u_chk (.CLK(CLK), .RST(RST), .RD(RD), .RDATA(RDATA),
  .REQ(REQ), .MC_EVENT(MC_EVENT), .FAIL(FAIL), .OUTCOME(OUTCOME),
  .OUTCOME_VALID(OUTCOME_VALID),
  .HOST_LOAD(HOST_LOAD), .HALTED(HALTED));
`default_nettype wire
